// >>> verilog/pcrr_regs.vh
// Offsets, field positions, reset values and write masks of the capability bank
// Assumes an 8-bit register address and 16-bit register data
`ifndef PCRR_REGS_VH
`define PCRR_REGS_VH

// ==========================================================================
// Register offsets
`define PCRR_ADDR_SLOT_FLAGS    8'h93
`define PCRR_ADDR_SLOT_NUMBER   8'h94
`define PCRR_ADDR_FTS_COUNTS    8'h95
`define PCRR_ADDR_CTO_MSI       8'h96
`define PCRR_ADDR_INTR_SUPPORT  8'h97

// ==========================================================================
// Reset values
`define PCRR_RST_SLOT_FLAGS     16'h0000
`define PCRR_RST_SLOT_NUMBER    16'h0000
`define PCRR_RST_FTS_COUNTS     16'h8080
`define PCRR_RST_CTO_MSI        16'h5000
`define PCRR_RST_INTR_SUPPORT   16'h0003

// ==========================================================================
// Writable bits, reserved bits stay zero
`define PCRR_WM_SLOT_FLAGS      16'hfc7f
`define PCRR_WM_SLOT_NUMBER     16'hfffc
`define PCRR_WM_FTS_COUNTS      16'hffff
`define PCRR_WM_CTO_MSI         16'hff1f
`define PCRR_WM_INTR_SUPPORT    16'h004f
`define PCRR_WM_SLOT_NUM_V10    16'hfff8
`define PCRR_WM_CTO_MSI_V10     16'hfb1f

// ==========================================================================
// Field positions
`define PCRR_SLOT_ATTN_BTN      0
`define PCRR_SLOT_PWR_CTRL      1
`define PCRR_SLOT_LATCH_SENSOR  2
`define PCRR_SLOT_ATTN_IND      3
`define PCRR_SLOT_PWR_IND       4
`define PCRR_SLOT_SURPRISE      5
`define PCRR_SLOT_HOT_PLUG      6
`define PCRR_SLOT_PWR_LIM_HI    15
`define PCRR_SLOT_PWR_LIM_LO    10
`define PCRR_NUM_INTERLOCK      2
`define PCRR_NUM_SLOT_HI        15
`define PCRR_NUM_SLOT_LO        3
`define PCRR_FTS_SEP_HI         7
`define PCRR_FTS_SEP_LO         0
`define PCRR_FTS_COM_HI         15
`define PCRR_FTS_COM_LO         8
`define PCRR_CTO_RANGE_HI       3
`define PCRR_CTO_RANGE_LO       0
`define PCRR_CTO_DISABLE        4
`define PCRR_ECRC_GEN           8
`define PCRR_ECRC_CHK           9
`define PCRR_NO_CMD_CPL         10
`define PCRR_MSI_MMC_HI         13
`define PCRR_MSI_MMC_LO         11
`define PCRR_MSI_ADDR64         14
`define PCRR_MSI_PVM            15
`define PCRR_INT_MSI            0
`define PCRR_INT_PIN_HI         3
`define PCRR_INT_PIN_LO         1
`define PCRR_INT_MSIX           6

`endif

// >>> verilog/pcrr_field_reg.v
// One 16-bit reconfigurable register with a write mask
// Assumes a single-cycle write strobe on the core clock
`timescale 1ns/1ps

module pcrr_field_reg
#(
	parameter [15:0] RESET_VAL = 16'h0000,
	parameter [15:0] WR_MASK   = 16'hffff
)
(
	input  wire        mclk_i,
	input  wire        rst_i,
	input  wire        wr_en_i,
	input  wire [15:0] wdata_i,
	output wire [15:0] q_o
);

	reg [15:0] q_r;
	wire [15:0] q_nxt;

	// ==========================================================================
	// Masked bits keep reset value, so reserved bits never leave zero
	assign q_nxt = (q_r & ~WR_MASK) | (wdata_i & WR_MASK); // RULE14

	always @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			q_r <= RESET_VAL;
		else if (wr_en_i)
			q_r <= q_nxt;
	end

	assign q_o = q_r;

endmodule

// >>> verilog/pcrr_cap_decode.v
// Decoders for completion timeout range code and message vector code
// Assumes codes come from registers on the same clock
`timescale 1ns/1ps

module pcrr_cap_decode
(
	input  wire       mclk_i,
	input  wire       rst_i,
	input  wire [3:0] cto_code_i,
	input  wire [2:0] msi_code_i,
	output reg  [3:0] cto_sets_o,
	output reg        cto_valid_o,
	output reg  [5:0] msi_vectors_o,
	output reg        msi_valid_o
);

	reg [3:0] cto_sets_nxt;
	reg       cto_valid_nxt;
	reg [5:0] msi_vectors_nxt;

	// ==========================================================================
	// Range sets as bits D C B A; reserved codes show no range
	always @*
	begin
		cto_valid_nxt = 1'b1;
		case (cto_code_i) // RULE8
		4'h1: cto_sets_nxt = 4'h1;
		4'h2: cto_sets_nxt = 4'h2;
		4'h3: cto_sets_nxt = 4'h3;
		4'h6: cto_sets_nxt = 4'h6;
		4'h7: cto_sets_nxt = 4'h7;
		4'he: cto_sets_nxt = 4'he;
		4'hf: cto_sets_nxt = 4'hf;
		default:
		begin
			cto_sets_nxt  = 4'h0;
			cto_valid_nxt = (cto_code_i == 4'h0);
		end
		endcase
		// Power of two, codes above 32 vectors undefined
		msi_vectors_nxt = (msi_code_i <= 3'h5) ? (6'h01 << msi_code_i) : 6'h00; // RULE11
	end

	always @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cto_sets_o    <= 4'h0;
			cto_valid_o   <= 1'b1;
			msi_vectors_o <= 6'h04;
			msi_valid_o   <= 1'b1;
		end
		else
		begin
			cto_sets_o    <= cto_sets_nxt;
			cto_valid_o   <= cto_valid_nxt;
			msi_vectors_o <= msi_vectors_nxt;
			msi_valid_o   <= (msi_code_i <= 3'h5);
		end
	end

endmodule

// >>> verilog/pcrr_top.v
// Reconfigurable capability registers for slot, training, timeout and message interrupts
// Assumes a same-clock master on the plain register port, one strobe per cycle
// Assumes consumers of the field outputs accept one clock of lag after a write
// Assumes writes to unmapped offsets are harmless and simply dropped
//
// Behaviour
// RULE1: Slot field bits 1 to 6 advertise power controller, latch sensor, attention and power indicator, surprise, hot-plug.
// RULE2: Surprise bit set advertises removal without prior notice.
// RULE3: Bits 15:10 of the slot flags register hold the slot power limit value, reset zero.
// RULE4: Bit 2 at 0x94 advertises an interlock, only in revision 1.1 builds.
// RULE5: Configuring software programs a fabric-unique physical slot number in bits 15:3 at 0x94.
// RULE6: Bits 7:0 at 0x95 give the training sequence count for separate clocks, reset 128.
// RULE7: Bits 15:8 at 0x95 give the training sequence count for common clock, reset 128.
// RULE8: The four-bit timeout range code selects the supported range sets, others reserved, reset zero.
// RULE9: Bit 4 of the timeout register advertises timeout disable support, reset zero.
// RULE10: Bit 10 advertises no-command-completed support, revision 1.1 builds only, reset zero.
// RULE11: Bits 13:11 request a power-of-two vector count, reset code 010 for four.
// RULE12: Bit 14 advertises 64-bit message addressing when one, reset one.
// RULE13: Bit 15 advertises per-vector masking, read-only to config software, reset zero.
// RULE14: Reserved bits read zero, ignore writes and advertise nothing.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`include "pcrr_regs.vh"

module pcrr_top
#(
	parameter SPEC_REV11 = 1
)
(
	input  wire        mclk_i,
	input  wire        rst_i,
	// Register port
	input  wire [7:0]  reg_addr_i,
	input  wire [15:0] reg_wdata_i,
	input  wire        reg_wr_i,
	input  wire        reg_rd_i,
	output reg  [15:0] reg_rdata_o,
	// Slot capability
	output reg         attn_button_present_o,
	output reg         power_ctrl_present_o,
	output reg         retention_latch_sensor_o,
	output reg         attn_indicator_present_o,
	output reg         power_indicator_present_o,
	output reg         surprise_removal_o,
	output reg         hot_plug_capable_o,
	output reg  [5:0]  slot_power_limit_o,
	output reg         em_interlock_present_o,
	output reg  [12:0] phys_slot_number_o,
	output reg         no_cmd_cpl_support_o,
	// Link training
	output reg  [7:0]  fast_train_count_separate_clock_o,
	output reg  [7:0]  fast_train_count_common_clock_o,
	// Completion timeout and end-to-end CRC
	output reg  [3:0]  cpl_timeout_ranges_o,
	output wire [3:0]  cpl_timeout_sets_o,
	output wire        cpl_timeout_code_valid_o,
	output reg         cpl_timeout_disable_sup_o,
	output reg         ecrc_gen_capable_o,
	output reg         ecrc_chk_capable_o,
	// Message interrupts
	output reg  [2:0]  msi_multi_msg_code_o,
	output wire [5:0]  msi_vector_count_o,
	output wire        msi_vector_code_valid_o,
	output reg         msi_addr64_capable_o,
	output reg         msi_per_vector_mask_o,
	output reg         msi_supported_o,
	output reg  [2:0]  intr_pin_o,
	output reg         msix_supported_o
);

	// ==========================================================================
	// Register table
	localparam NREG = 5;

	// Revision 1.0 builds keep interlock and no-command-completed bits at zero
	localparam [15:0] WM_NUM = (SPEC_REV11 != 0) ? `PCRR_WM_SLOT_NUMBER : `PCRR_WM_SLOT_NUM_V10;
	localparam [15:0] WM_CTO = (SPEC_REV11 != 0) ? `PCRR_WM_CTO_MSI : `PCRR_WM_CTO_MSI_V10;

	localparam [16*NREG-1:0] RST_VEC =
	{
		`PCRR_RST_INTR_SUPPORT,
		`PCRR_RST_CTO_MSI,
		`PCRR_RST_FTS_COUNTS,
		`PCRR_RST_SLOT_NUMBER,
		`PCRR_RST_SLOT_FLAGS
	};

	localparam [16*NREG-1:0] MASK_VEC =
	{
		`PCRR_WM_INTR_SUPPORT,
		WM_CTO,
		`PCRR_WM_FTS_COUNTS,
		WM_NUM,
		`PCRR_WM_SLOT_FLAGS
	};

	wire [16*NREG-1:0] reg_q;
	wire [15:0]        slot_flags_q;
	wire [15:0]        slot_number_q;
	wire [15:0]        fts_counts_q;
	wire [15:0]        cto_msi_q;
	wire [15:0]        intr_support_q;
	reg  [15:0]        rdata_nxt;
	reg  [NREG-1:0]    wr_hit;

	// ==========================================================================
	// Write decode, one hit per table entry
	always @*
	begin
		wr_hit = {NREG{1'b0}};
		if (reg_wr_i)
		begin
			if (reg_addr_i == `PCRR_ADDR_SLOT_FLAGS)
				wr_hit[0] = 1'b1;
			else if (reg_addr_i == `PCRR_ADDR_SLOT_NUMBER)
				wr_hit[1] = 1'b1;
			else if (reg_addr_i == `PCRR_ADDR_FTS_COUNTS)
				wr_hit[2] = 1'b1;
			else if (reg_addr_i == `PCRR_ADDR_CTO_MSI)
				wr_hit[3] = 1'b1;
			else if (reg_addr_i == `PCRR_ADDR_INTR_SUPPORT)
				wr_hit[4] = 1'b1;
			else
				wr_hit = {NREG{1'b0}}; // RULE14
		end
	end

	// ==========================================================================
	// Storage, one register per table entry
	genvar gi;
	generate
		for (gi = 0; gi < NREG; gi = gi + 1)
		begin : g_reg
			pcrr_field_reg
			#(
				.RESET_VAL (RST_VEC[16*gi +: 16]),
				.WR_MASK   (MASK_VEC[16*gi +: 16])
			)
			u_reg
			(
				.mclk_i  (mclk_i),
				.rst_i   (rst_i),
				.wr_en_i (wr_hit[gi]),
				.wdata_i (reg_wdata_i),
				.q_o     (reg_q[16*gi +: 16])
			);
		end
	endgenerate

	assign slot_flags_q   = reg_q[15:0];
	assign slot_number_q  = reg_q[31:16];
	assign fts_counts_q   = reg_q[47:32];
	assign cto_msi_q      = reg_q[63:48];
	assign intr_support_q = reg_q[79:64];

	// ==========================================================================
	// Read back; unmapped offsets and idle cycles return zero
	always @*
	begin
		rdata_nxt = 16'h0000;
		if (reg_rd_i)
		begin
			if (reg_addr_i == `PCRR_ADDR_SLOT_FLAGS)
				rdata_nxt = slot_flags_q;
			else if (reg_addr_i == `PCRR_ADDR_SLOT_NUMBER)
				rdata_nxt = slot_number_q;
			else if (reg_addr_i == `PCRR_ADDR_FTS_COUNTS)
				rdata_nxt = fts_counts_q;
			else if (reg_addr_i == `PCRR_ADDR_CTO_MSI)
				rdata_nxt = cto_msi_q;
			else if (reg_addr_i == `PCRR_ADDR_INTR_SUPPORT)
				rdata_nxt = intr_support_q;
			else
				rdata_nxt = 16'h0000; // RULE14
		end
	end

	always @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			reg_rdata_o <= 16'h0000;
		else
			reg_rdata_o <= rdata_nxt;
	end

	// ==========================================================================
	// Output reset values follow the stored reset words, so both always agree
	localparam [15:0] RST_FLAGS = `PCRR_RST_SLOT_FLAGS;
	localparam [15:0] RST_NUM   = `PCRR_RST_SLOT_NUMBER;
	localparam [15:0] RST_FTS   = `PCRR_RST_FTS_COUNTS;
	localparam [15:0] RST_CTO   = `PCRR_RST_CTO_MSI;
	localparam [15:0] RST_INTR  = `PCRR_RST_INTR_SUPPORT;

	// ==========================================================================
	// Slot presence flags at 0x93
	always @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			attn_button_present_o     <= RST_FLAGS[`PCRR_SLOT_ATTN_BTN];
			power_ctrl_present_o      <= RST_FLAGS[`PCRR_SLOT_PWR_CTRL];
			retention_latch_sensor_o  <= RST_FLAGS[`PCRR_SLOT_LATCH_SENSOR];
			attn_indicator_present_o  <= RST_FLAGS[`PCRR_SLOT_ATTN_IND];
			power_indicator_present_o <= RST_FLAGS[`PCRR_SLOT_PWR_IND];
			surprise_removal_o        <= RST_FLAGS[`PCRR_SLOT_SURPRISE];
			hot_plug_capable_o        <= RST_FLAGS[`PCRR_SLOT_HOT_PLUG];
		end
		else
		begin
			attn_button_present_o     <= slot_flags_q[`PCRR_SLOT_ATTN_BTN];
			power_ctrl_present_o      <= slot_flags_q[`PCRR_SLOT_PWR_CTRL]; // RULE1
			retention_latch_sensor_o  <= slot_flags_q[`PCRR_SLOT_LATCH_SENSOR]; // RULE1
			attn_indicator_present_o  <= slot_flags_q[`PCRR_SLOT_ATTN_IND]; // RULE1
			power_indicator_present_o <= slot_flags_q[`PCRR_SLOT_PWR_IND]; // RULE1
			surprise_removal_o        <= slot_flags_q[`PCRR_SLOT_SURPRISE]; // RULE2
			hot_plug_capable_o        <= slot_flags_q[`PCRR_SLOT_HOT_PLUG]; // RULE1
		end
	end

	// ==========================================================================
	// Slot power limit at 0x93
	always @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			slot_power_limit_o <= RST_FLAGS[`PCRR_SLOT_PWR_LIM_HI:`PCRR_SLOT_PWR_LIM_LO];
		end
		else
		begin
			slot_power_limit_o <= slot_flags_q[`PCRR_SLOT_PWR_LIM_HI:`PCRR_SLOT_PWR_LIM_LO]; // RULE3
		end
	end

	// ==========================================================================
	// Interlock and physical slot number at 0x94
	always @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			em_interlock_present_o <= RST_NUM[`PCRR_NUM_INTERLOCK];
			phys_slot_number_o     <= RST_NUM[`PCRR_NUM_SLOT_HI:`PCRR_NUM_SLOT_LO];
		end
		else
		begin
			em_interlock_present_o <= slot_number_q[`PCRR_NUM_INTERLOCK]; // RULE4
			// Uniqueness across the fabric is up to software
			phys_slot_number_o     <= slot_number_q[`PCRR_NUM_SLOT_HI:`PCRR_NUM_SLOT_LO]; // RULE5
		end
	end

	// ==========================================================================
	// Fast training counts at 0x95
	always @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			fast_train_count_separate_clock_o <= RST_FTS[`PCRR_FTS_SEP_HI:`PCRR_FTS_SEP_LO];
			fast_train_count_common_clock_o   <= RST_FTS[`PCRR_FTS_COM_HI:`PCRR_FTS_COM_LO];
		end
		else
		begin
			fast_train_count_separate_clock_o <= fts_counts_q[`PCRR_FTS_SEP_HI:`PCRR_FTS_SEP_LO]; // RULE6
			fast_train_count_common_clock_o   <= fts_counts_q[`PCRR_FTS_COM_HI:`PCRR_FTS_COM_LO]; // RULE7
		end
	end

	// ==========================================================================
	// Completion timeout fields at 0x96
	always @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cpl_timeout_ranges_o      <= RST_CTO[`PCRR_CTO_RANGE_HI:`PCRR_CTO_RANGE_LO];
			cpl_timeout_disable_sup_o <= RST_CTO[`PCRR_CTO_DISABLE];
		end
		else
		begin
			cpl_timeout_ranges_o      <= cto_msi_q[`PCRR_CTO_RANGE_HI:`PCRR_CTO_RANGE_LO]; // RULE8
			cpl_timeout_disable_sup_o <= cto_msi_q[`PCRR_CTO_DISABLE]; // RULE9
		end
	end

	// ==========================================================================
	// CRC and command completion bits at 0x96
	always @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ecrc_gen_capable_o   <= RST_CTO[`PCRR_ECRC_GEN];
			ecrc_chk_capable_o   <= RST_CTO[`PCRR_ECRC_CHK];
			no_cmd_cpl_support_o <= RST_CTO[`PCRR_NO_CMD_CPL];
		end
		else
		begin
			ecrc_gen_capable_o   <= cto_msi_q[`PCRR_ECRC_GEN];
			ecrc_chk_capable_o   <= cto_msi_q[`PCRR_ECRC_CHK];
			// Revision 1.0 builds hold this low through the write mask
			no_cmd_cpl_support_o <= cto_msi_q[`PCRR_NO_CMD_CPL]; // RULE10
		end
	end

	// ==========================================================================
	// Message interrupt control at 0x96
	always @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			msi_multi_msg_code_o  <= RST_CTO[`PCRR_MSI_MMC_HI:`PCRR_MSI_MMC_LO];
			msi_addr64_capable_o  <= RST_CTO[`PCRR_MSI_ADDR64];
			msi_per_vector_mask_o <= RST_CTO[`PCRR_MSI_PVM];
		end
		else
		begin
			msi_multi_msg_code_o  <= cto_msi_q[`PCRR_MSI_MMC_HI:`PCRR_MSI_MMC_LO]; // RULE11
			msi_addr64_capable_o  <= cto_msi_q[`PCRR_MSI_ADDR64]; // RULE12
			// Writable here; only the config space view is read-only
			msi_per_vector_mask_o <= cto_msi_q[`PCRR_MSI_PVM]; // RULE13
		end
	end

	// ==========================================================================
	// Interrupt support at 0x97
	always @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			msi_supported_o  <= RST_INTR[`PCRR_INT_MSI];
			intr_pin_o       <= RST_INTR[`PCRR_INT_PIN_HI:`PCRR_INT_PIN_LO];
			msix_supported_o <= RST_INTR[`PCRR_INT_MSIX];
		end
		else
		begin
			msi_supported_o  <= intr_support_q[`PCRR_INT_MSI];
			intr_pin_o       <= intr_support_q[`PCRR_INT_PIN_HI:`PCRR_INT_PIN_LO];
			msix_supported_o <= intr_support_q[`PCRR_INT_MSIX];
		end
	end

	// ==========================================================================
	// Decoded views, registered inside, same latency as the raw fields
	pcrr_cap_decode u_decode
	(
		.mclk_i        (mclk_i),
		.rst_i         (rst_i),
		.cto_code_i    (cto_msi_q[`PCRR_CTO_RANGE_HI:`PCRR_CTO_RANGE_LO]),
		.msi_code_i    (cto_msi_q[`PCRR_MSI_MMC_HI:`PCRR_MSI_MMC_LO]),
		.cto_sets_o    (cpl_timeout_sets_o),
		.cto_valid_o   (cpl_timeout_code_valid_o),
		.msi_vectors_o (msi_vector_count_o),
		.msi_valid_o   (msi_vector_code_valid_o)
	);

endmodule

// >>> dv/pcrr_asserts.sv
// Concurrent checks on the capability register bank ports
// Assumes the default build, revision 1.1 bits writable
`timescale 1ns/1ps

module pcrr_asserts
(
	input wire        mclk_i,
	input wire        rst_i,
	input wire [7:0]  reg_addr_i,
	input wire [15:0] reg_wdata_i,
	input wire        reg_wr_i,
	input wire        reg_rd_i,
	input wire [15:0] reg_rdata_o,
	input wire        surprise_removal_o,
	input wire [5:0]  slot_power_limit_o,
	input wire        em_interlock_present_o,
	input wire [12:0] phys_slot_number_o,
	input wire [7:0]  fast_train_count_separate_clock_o,
	input wire [7:0]  fast_train_count_common_clock_o,
	input wire [3:0]  cpl_timeout_ranges_o,
	input wire        cpl_timeout_disable_sup_o,
	input wire [5:0]  msi_vector_count_o,
	input wire        msi_addr64_capable_o,
	input wire        msi_per_vector_mask_o
);
	// ==========================================================
	// Write effects show two edges after the strobe
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	rd_idle_zero_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
		else $error("read data not zero outside read");
	sep_count_a: assert property (reg_wr_i && reg_addr_i == 8'h95 |-> ##2 fast_train_count_separate_clock_o == $past(reg_wdata_i[7:0], 2))
		else $error("separate clock count wrong");
	com_count_a: assert property (reg_wr_i && reg_addr_i == 8'h95 |-> ##2 fast_train_count_common_clock_o == $past(reg_wdata_i[15:8], 2))
		else $error("common clock count wrong");
	power_limit_a: assert property (reg_wr_i && reg_addr_i == 8'h93 |-> ##2 slot_power_limit_o == $past(reg_wdata_i[15:10], 2))
		else $error("slot power limit wrong");
	surprise_bit_a: assert property (reg_wr_i && reg_addr_i == 8'h93 |-> ##2 surprise_removal_o == $past(reg_wdata_i[5], 2))
		else $error("surprise removal wrong");
	slot_read_a: assert property (reg_rd_i && reg_addr_i == 8'h94 |=> reg_rdata_o == {phys_slot_number_o, em_interlock_present_o, 2'b00})
		else $error("slot number read mismatch");
	vector_count_a: assert property (reg_wr_i && reg_addr_i == 8'h96 |-> ##2 msi_vector_count_o == ($past(reg_wdata_i[13:11], 2) <= 3'd5 ? 6'd1 << $past(reg_wdata_i[13:11], 2) : 6'd0))
		else $error("vector count wrong");
	cto_field_a: assert property (reg_wr_i && reg_addr_i == 8'h96 |-> ##2 cpl_timeout_ranges_o == $past(reg_wdata_i[3:0], 2) && cpl_timeout_disable_sup_o == $past(reg_wdata_i[4], 2))
		else $error("timeout fields wrong");
	msi_addr_a: assert property (reg_wr_i && reg_addr_i == 8'h96 |-> ##2 msi_addr64_capable_o == $past(reg_wdata_i[14], 2) && msi_per_vector_mask_o == $past(reg_wdata_i[15], 2))
		else $error("message address or mask wrong");
	slot_rsvd_a: assert property (reg_rd_i && reg_addr_i == 8'h93 |=> reg_rdata_o[9:7] == 3'b000)
		else $error("reserved slot bits not zero");
	cover property (reg_wr_i && reg_addr_i == 8'h95);
	cover property (reg_rd_i ##1 reg_rdata_o != 16'h0000);
	cover property (reg_wr_i && reg_addr_i == 8'h96 && reg_wdata_i[13:11] > 3'd5);
endmodule

bind pcrr_top pcrr_asserts chk_u (.mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
	.surprise_removal_o(surprise_removal_o), .slot_power_limit_o(slot_power_limit_o),
	.em_interlock_present_o(em_interlock_present_o), .phys_slot_number_o(phys_slot_number_o),
	.fast_train_count_separate_clock_o(fast_train_count_separate_clock_o),
	.fast_train_count_common_clock_o(fast_train_count_common_clock_o),
	.cpl_timeout_ranges_o(cpl_timeout_ranges_o), .cpl_timeout_disable_sup_o(cpl_timeout_disable_sup_o),
	.msi_vector_count_o(msi_vector_count_o), .msi_addr64_capable_o(msi_addr64_capable_o),
	.msi_per_vector_mask_o(msi_per_vector_mask_o));

// >>> dv/tb.sv
// Self-checking bench for the capability register bank
// Assumes the default build, revision 1.1 bits writable
`timescale 1ns/1ps

module tb;
	logic        mclk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [7:0]  reg_addr_i = 8'h00;
	logic [15:0] reg_wdata_i = 16'h0000;
	logic        reg_wr_i = 1'b0;
	logic        reg_rd_i = 1'b0;
	wire  [15:0] reg_rdata_o;
	wire  [6:0]  slot_bits;
	wire  [5:0]  plim, vcount;
	wire  [12:0] slot_num;
	wire  [7:0]  sep, com;
	wire  [3:0]  cto, sets;
	wire  [2:0]  mcode, pin;
	wire         lock, nocmd, cvld, cdis, egen, echk, vvld, a64, pvm, msi, msix;
	int          miscompares = 0;
	int          checks_done = 0;

	pcrr_top dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.attn_button_present_o(slot_bits[0]), .power_ctrl_present_o(slot_bits[1]),
		.retention_latch_sensor_o(slot_bits[2]), .attn_indicator_present_o(slot_bits[3]),
		.power_indicator_present_o(slot_bits[4]), .surprise_removal_o(slot_bits[5]),
		.hot_plug_capable_o(slot_bits[6]), .slot_power_limit_o(plim), .em_interlock_present_o(lock),
		.phys_slot_number_o(slot_num), .no_cmd_cpl_support_o(nocmd),
		.fast_train_count_separate_clock_o(sep), .fast_train_count_common_clock_o(com),
		.cpl_timeout_ranges_o(cto), .cpl_timeout_sets_o(sets), .cpl_timeout_code_valid_o(cvld),
		.cpl_timeout_disable_sup_o(cdis), .ecrc_gen_capable_o(egen), .ecrc_chk_capable_o(echk),
		.msi_multi_msg_code_o(mcode), .msi_vector_count_o(vcount), .msi_vector_code_valid_o(vvld),
		.msi_addr64_capable_o(a64), .msi_per_vector_mask_o(pvm), .msi_supported_o(msi),
		.intr_pin_o(pin), .msix_supported_o(msix));

	// ==========================================================
	// Clock and shared tasks
	always #2 mclk_i = ~mclk_i;

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge mclk_i);
		reg_wr_i <= 1'b0;
	endtask

	// Data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge mclk_i);
		reg_rd_i <= 1'b0;
		#1 d = reg_rdata_o;
	endtask

	task automatic settle;
		@(posedge mclk_i);
		#1;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset;
		logic [15:0] d;
		logic [15:0] exp [5] = '{16'h0000, 16'h0000, 16'h8080, 16'h5000, 16'h0003};
		for (int i = 0; i < 5; i++)
		begin
			rd(8'h93 + i[7:0], d);
			check("reset value", d, exp[i]);
		end
		check("reset outputs", {vcount, a64, pvm, cdis, nocmd}, {6'd4, 4'b1000});
		check("reset counts", {com, sep}, 16'h8080);
	endtask

	task automatic t_masks;
		logic [15:0] d;
		logic [15:0] msk [7] = '{16'h0000, 16'hfc7f, 16'hfffc, 16'hffff, 16'hff1f, 16'h004f, 16'h0000};
		for (int i = 0; i < 7; i++)
		begin
			wr(8'h92 + i[7:0], 16'hffff);
			rd(8'h92 + i[7:0], d);
			check("masked readback", d, msk[i]);
		end
		check("slot flags all set", {slot_bits, plim}, {7'h7f, 6'h3f});
		check("slot number all set", {lock, slot_num}, {1'b1, 13'h1fff});
		check("interrupt pin", {msix, pin, msi}, 16'h001f);
		wr(8'h93, 16'h0020);
		settle;
		check("surprise only", {plim, slot_bits}, 16'h0020);
		wr(8'h94, 16'hfff8);
		settle;
		check("slot number", {slot_num, lock}, 16'h3ffe);
	endtask

	task automatic t_fts;
		logic [15:0] d;
		wr(8'h95, 16'h1234);
		rd(8'h95, d);
		check("count readback", d, 16'h1234);
		check("count outputs", {com, sep}, 16'h1234);
	endtask

	// Reserved timeout codes stay stored but decode to nothing
	task automatic t_cto;
		logic ok;
		for (int c = 0; c < 16; c++)
		begin
			wr(8'h96, {11'h000, c[0], c[3:0]});
			settle;
			ok = c inside {0, 1, 2, 3, 6, 7, 14, 15};
			check("timeout raw", {cdis, cto}, {c[0], c[3:0]});
			check("timeout decode", {cvld, sets}, ok ? {1'b1, c[3:0]} : 5'h00);
		end
	endtask

	task automatic t_msi;
		for (int c = 0; c < 8; c++)
		begin
			wr(8'h96, {2'b10, c[2:0], 11'h700});
			settle;
			check("vector count", {vvld, vcount}, c <= 5 ? {1'b1, 6'd1 << c} : 7'h00);
			check("message flags", {mcode, a64, pvm, egen, echk, nocmd}, {c[2:0], 5'b01111});
		end
	endtask

	task automatic print_verdict;
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial
	begin
		repeat (5) @(posedge mclk_i);
		rst_i <= 1'b0;
		t_reset;
		t_masks;
		t_fts;
		t_cto;
		t_msi;
		print_verdict;
	end

	// Whole run is about 125 cycles
	initial
	begin
		#40000;
		miscompares++;
		print_verdict;
	end
endmodule
